// ---- cfg_guard_pkg.sv ----
// Package with map, field layout and types for the configuration word guard
package cfg_guard_pkg;

  // Data width of a program memory word
  localparam int WORD_W = 14;
  // Width of a configuration space address (program addresses are 14 bits)
  localparam int ADDR_W = 16;

  // Configuration space word addresses
  localparam logic [15:0] USER_ID_FIRST = 16'h8000;
  localparam logic [15:0] USER_ID_LAST = 16'h8003;
  localparam logic [15:0] DEV_REV_ADDR = 16'h8006;
  localparam logic [15:0] CFG_ONE_ADDR = 16'h8007;
  localparam logic [15:0] CFG_TWO_ADDR = 16'h8008;
  // Number of user identification words
  localparam int USER_ID_COUNT = 4;

  // Blank (erased) word value
  localparam logic [13:0] BLANK_WORD = 14'h3fff;
  // Unimplemented positions of word two: bits 8..5 and 3..2
  localparam logic [13:0] CFG2_UNIMPL_MASK = 14'h01ec;
  // Code protect bit position in word one (active low)
  localparam int CODE_PROTECT_BIT = 7;

  // Self-write protect field encodings
  localparam logic [1:0] WP_OFF = 2'h3;
  localparam logic [1:0] WP_BOOT = 2'h2;
  localparam logic [1:0] WP_HALF = 2'h1;
  localparam logic [1:0] WP_ALL = 2'h0;

  // Last protected address for each range and array size
  localparam logic [13:0] BOOT_END = 14'h01ff;
  localparam logic [13:0] HALF_END_SMALL = 14'h0fff;
  localparam logic [13:0] ALL_END_SMALL = 14'h1fff;
  localparam logic [13:0] HALF_END_LARGE = 14'h1fff;
  localparam logic [13:0] ALL_END_LARGE = 14'h3fff;

  // Layout of configuration word two, bit 13 first
  typedef struct packed {
    logic lowVoltProgEnable;
    logic debugModeN;
    logic lowPowerBrownoutN;
    logic brownoutTripSelect;
    logic stackFaultResetEnable;
    logic [3:0] unimplHigh;
    logic regulatorCapPinN;
    logic [1:0] unimplLow;
    logic [1:0] selfWriteProtectRange;
  } cfg2_word_t;

  // Layout of the identification word
  typedef struct packed {
    logic [8:0] partCodeField;
    logic [4:0] siliconRevisionField;
  } dev_rev_t;

  // Decoded controls handed to the rest of the chip
  typedef struct packed {
    logic lowVoltEntryAllowed;
    logic debuggerEnable;
    logic progPinsGpio;
    logic lowPowerBrownoutEnable;
    logic brownoutTripLow;
    logic stackFaultResetEnable;
    logic regulatorCapFunction;
    logic codeProtectActive;
  } cfg_controls_t;

  // Load sequencing states
  typedef enum logic {LOAD, RUN} load_state_t;

endpackage

// ---- config_word_guard.sv ----
// Configuration word two decode, code and self-write protection, ID words
`timescale 1ns/1ps
// Functional notes
// - Low-voltage entry allowed only when bit 13 set
// - Bit 12 zero reserves programming pins for debugger
// - Bit 11 zero enables low-power brown-out detector
// - Bit 10 one selects low brown-out trip
// - Bit 9 one lets stack faults reset
// - Unimplemented bits 8-5, 3-2 read as one
// - Capacitor pin function only on regulator variant
// - Small array self-write ranges per field
// - Large array self-write ranges per field
// - Code protect blocks external access, reads zero
// - CPU reads always pass; writes use range
// - Four user ID words readable and writable
// - Identification word holds part and revision
// - Blank configuration reads all ones
// - Word two lives at configuration address 8008h
module config_word_guard #(
  parameter bit LARGE_ARRAY = 1'b0,
  parameter bit REGULATOR_PRESENT = 1'b1,
  // Arbitrary part code, not a real device value
  parameter logic [8:0] PART_CODE = 9'h0a5,
  // Arbitrary revision code
  parameter logic [4:0] SILICON_REV = 5'h01
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [13:0] nvmCfgOne,
  input wire logic [13:0] nvmCfgTwo,
  input wire logic nvmBlank,
  input wire logic lowVoltKeySeen,
  input wire logic highVoltOnResetPin,
  input wire logic stackOverflow,
  input wire logic stackUnderflow,
  input wire logic cpuRdReq,
  input wire logic cpuWrReq,
  input wire logic [13:0] cpuWrAddr,
  input wire logic extRdReq,
  input wire logic extWrReq,
  input wire logic [13:0] memRdData,
  input wire logic [15:0] regAddr,
  input wire logic [13:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output cfg_guard_pkg::cfg_controls_t controls,
  output logic progModeEntry,
  output logic stackFaultReset,
  output logic cpuRdGrant,
  output logic cpuWrGrant,
  output logic cpuWrBlocked,
  output logic extRdGrant,
  output logic extWrGrant,
  output logic [13:0] extRdData,
  output logic [13:0] regRdData,
  output logic configValid
);
  import cfg_guard_pkg::*;

  // Load sequencer state
  load_state_t stateReg;
  // Latched configuration words
  cfg2_word_t cfgTwoReg;
  logic [13:0] cfgOneReg;
  // User identification storage
  logic [13:0] userIdReg [USER_ID_COUNT];
  // Identification word assembled from parameters
  dev_rev_t devRev;
  // Combinational decode of the latched word
  cfg_controls_t controlsNext;
  // Last protected address for the current range
  logic [13:0] protEnd;

  // Last protected address for a field code and array size
  function automatic logic [13:0] prot_end(input logic [1:0] code, input bit bigArray);
    logic [13:0] endAddr;
    endAddr = BOOT_END;
    case (code)
      WP_BOOT: begin
        endAddr = BOOT_END;
      end
      WP_HALF: begin
        endAddr = bigArray ? HALF_END_LARGE : HALF_END_SMALL;
      end
      WP_ALL: begin
        endAddr = bigArray ? ALL_END_LARGE : ALL_END_SMALL;
      end
      default: begin
        endAddr = BOOT_END;
      end
    endcase
    return endAddr;
  endfunction

  // True when a configuration address lies in the user ID block
  function automatic logic is_user_id(input logic [15:0] addr);
    return (addr >= USER_ID_FIRST) && (addr <= USER_ID_LAST);
  endfunction

  // One driver for the whole identification word
  assign devRev = '{partCodeField: PART_CODE, siliconRevisionField: SILICON_REV};

  // Load sequencer: capture once after reset release, then hold
  always_ff @(posedge clk) begin
    if (rst) begin
      stateReg <= LOAD;
    end else begin
      stateReg <= RUN;
    end
  end

  // Configuration capture on the first cycle after reset release
  always_ff @(posedge clk) begin
    if (rst) begin
      cfgTwoReg <= cfg2_word_t'(BLANK_WORD);
      cfgOneReg <= BLANK_WORD;
    end else if (stateReg == LOAD) begin
      // Blank array falls back to all ones
      if (nvmBlank) begin
        cfgTwoReg <= cfg2_word_t'(BLANK_WORD);
        cfgOneReg <= BLANK_WORD;
      end else begin
        cfgTwoReg <= cfg2_word_t'(nvmCfgTwo | CFG2_UNIMPL_MASK);
        cfgOneReg <= nvmCfgOne;
      end
    end
  end

  // Decode of the latched word into chip controls
  always_comb begin
    controlsNext.lowVoltEntryAllowed = cfgTwoReg.lowVoltProgEnable;
    controlsNext.debuggerEnable = ~cfgTwoReg.debugModeN;
    controlsNext.progPinsGpio = cfgTwoReg.debugModeN;
    controlsNext.lowPowerBrownoutEnable = ~cfgTwoReg.lowPowerBrownoutN;
    controlsNext.brownoutTripLow = cfgTwoReg.brownoutTripSelect;
    controlsNext.stackFaultResetEnable = cfgTwoReg.stackFaultResetEnable;
    // Regulator-less variant ignores the bit
    controlsNext.regulatorCapFunction = REGULATOR_PRESENT &&
      !cfgTwoReg.regulatorCapPinN;
    controlsNext.codeProtectActive = ~cfgOneReg[CODE_PROTECT_BIT];
  end

  assign protEnd = prot_end(cfgTwoReg.selfWriteProtectRange, LARGE_ARRAY);

  // Registered controls; quiet until configuration is loaded
  always_ff @(posedge clk) begin
    if (rst) begin
      controls <= '0;
      configValid <= 1'b0;
    end else begin
      if (stateReg == RUN) begin
        controls <= controlsNext;
      end else begin
        // Capture cycle: the latch still holds its reset value, show nothing
        controls <= '0;
      end
      configValid <= (stateReg == RUN);
    end
  end

  // Programming mode entry: key needs enable, high voltage always works
  always_ff @(posedge clk) begin
    if (rst) begin
      progModeEntry <= 1'b0;
    end else begin
      progModeEntry <= highVoltOnResetPin ||
        (lowVoltKeySeen && cfgTwoReg.lowVoltProgEnable);
    end
  end

  // Stack fault reset request
  always_ff @(posedge clk) begin
    if (rst) begin
      stackFaultReset <= 1'b0;
    end else begin
      stackFaultReset <= (stackOverflow || stackUnderflow) &&
        cfgTwoReg.stackFaultResetEnable;
    end
  end

  // CPU access path: reads always pass, writes checked against range
  always_ff @(posedge clk) begin
    if (rst) begin
      cpuRdGrant <= 1'b0;
      cpuWrGrant <= 1'b0;
      cpuWrBlocked <= 1'b0;
    end else begin
      cpuRdGrant <= cpuRdReq;
      if (cpuWrReq && cfgTwoReg.selfWriteProtectRange != WP_OFF &&
          cpuWrAddr <= protEnd) begin
        // Inside the protected block
        cpuWrGrant <= 1'b0;
        cpuWrBlocked <= 1'b1;
      end else begin
        // Outside it, or protection off
        cpuWrGrant <= cpuWrReq;
        cpuWrBlocked <= 1'b0;
      end
    end
  end

  // External programmer path gated by code protect
  always_ff @(posedge clk) begin
    if (rst) begin
      extRdGrant <= 1'b0;
      extWrGrant <= 1'b0;
      extRdData <= '0;
    end else begin
      extRdGrant <= extRdReq && cfgOneReg[CODE_PROTECT_BIT];
      extWrGrant <= extWrReq && cfgOneReg[CODE_PROTECT_BIT];
      if (extRdReq && cfgOneReg[CODE_PROTECT_BIT]) begin
        extRdData <= memRdData;
      end else begin
        // Protected or idle reads show zeros
        extRdData <= '0;
      end
    end
  end

  // User ID storage, writable by the running program
  generate
    for (genvar i = 0; i < USER_ID_COUNT; i++) begin : g_uid
      always_ff @(posedge clk) begin
        if (rst) begin
          userIdReg[i] <= BLANK_WORD;
        end else if (regWr && regAddr == USER_ID_FIRST + 16'(i)) begin
          userIdReg[i] <= regWrData;
        end
      end
    end
  endgenerate

  // Register read port: data one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      regRdData <= '0;
    end else if (regRd) begin
      if (is_user_id(regAddr)) begin
        regRdData <= userIdReg[regAddr[1:0]];
      end else if (regAddr == DEV_REV_ADDR) begin
        regRdData <= devRev;
      end else if (regAddr == CFG_ONE_ADDR) begin
        regRdData <= cfgOneReg;
      end else if (regAddr == CFG_TWO_ADDR) begin
        regRdData <= cfgTwoReg;
      end else begin
        // Unmapped address reads zero
        regRdData <= '0;
      end
    end else begin
      regRdData <= '0;
    end
  end

  // Unimplemented bits of word two always read as one
  a_unimpl_ones: assert property (@(posedge clk) disable iff (rst)
    $past(regRd) && $past(regAddr) == CFG_TWO_ADDR |->
      (regRdData & CFG2_UNIMPL_MASK) == CFG2_UNIMPL_MASK)
    else $error("unimplemented bits not one");

  // Protected external read returns zeros and no grant
  a_protect_read_zero: assert property (@(posedge clk) disable iff (rst)
    extRdReq && !cfgOneReg[CODE_PROTECT_BIT] |=> extRdData == '0 && !extRdGrant)
    else $error("protected read leaked data");

  // Write in protected range never granted
  a_selfwrite_block: assert property (@(posedge clk) disable iff (rst)
    cpuWrReq && cfgTwoReg.selfWriteProtectRange != WP_OFF && cpuWrAddr <= protEnd
      |=> cpuWrBlocked && !cpuWrGrant)
    else $error("protected self-write granted");

  // Write outside range granted next cycle
  a_selfwrite_pass: assert property (@(posedge clk) disable iff (rst)
    cpuWrReq && (cfgTwoReg.selfWriteProtectRange == WP_OFF || cpuWrAddr > protEnd)
      |=> cpuWrGrant)
    else $error("unprotected self-write refused");

  // CPU reads pass whatever the protection
  a_cpu_read_pass: assert property (@(posedge clk) disable iff (rst)
    cpuRdReq |=> cpuRdGrant)
    else $error("cpu read refused");

  // Low-voltage key without enable and without high voltage gives no entry
  a_lowvolt_entry: assert property (@(posedge clk) disable iff (rst)
    lowVoltKeySeen && !highVoltOnResetPin && !cfgTwoReg.lowVoltProgEnable
      |=> !progModeEntry)
    else $error("low-voltage entry while disabled");

  // Stack fault reset follows the enable bit
  a_stack_reset: assert property (@(posedge clk) disable iff (rst)
    (stackOverflow || stackUnderflow) |=>
      stackFaultReset == $past(cfgTwoReg.stackFaultResetEnable))
    else $error("stack fault reset mismatch");

  // Latched configuration stays put after load
  a_config_stable: assert property (@(posedge clk) disable iff (rst)
    configValid && $past(configValid) |-> $stable(controls) && $stable(cfgTwoReg))
    else $error("configuration changed after load");

  // Identification word returns part and revision
  a_ident_word: assert property (@(posedge clk) disable iff (rst)
    regRd && regAddr == DEV_REV_ADDR |=> regRdData == {PART_CODE, SILICON_REV})
    else $error("identification word wrong");

  // Written user ID reads back
  a_user_id_rw: assert property (@(posedge clk) disable iff (rst)
    regWr && is_user_id(regAddr) ##1 regRd && regAddr == $past(regAddr)
      |=> regRdData == $past(regWrData, 2))
    else $error("user ID readback wrong");

  // Capacitor function absent on regulator-less variant
  a_cap_variant: assert property (@(posedge clk) disable iff (rst)
    !REGULATOR_PRESENT |-> !controls.regulatorCapFunction)
    else $error("capacitor function on regulator-less part");

endmodule

// ---- prog_model.sv ----
// Model of the external programmer that drives array access and entry levels
`timescale 1ns/1ps
module prog_model (
  input wire logic clk,
  output logic extRdReq,
  output logic extWrReq,
  output logic [13:0] memRdData,
  output logic lowVoltKeySeen,
  output logic highVoltOnResetPin
);
  // Idle at time zero: no request, no entry key, no high voltage
  initial begin
    extRdReq = 1'b0;
    extWrReq = 1'b0;
    memRdData = 14'h0000;
    lowVoltKeySeen = 1'b0;
    highVoltOnResetPin = 1'b0;
  end
  // Array data nobody holds moves every cycle, so a stale value never looks valid
  always @(negedge clk) begin
    if (!extRdReq && !extWrReq) begin
      memRdData <= ~memRdData;
    end
  end
  // One external access, held until the taking edge, then released
  task automatic access(input logic rd, input logic [13:0] data);
    @(posedge clk);
    extRdReq <= rd;
    extWrReq <= !rd;
    memRdData <= data;
    @(posedge clk);
    extRdReq <= 1'b0;
    extWrReq <= 1'b0;
  endtask
  // Entry levels: low-voltage key and high voltage on the reset pin
  task automatic levels(input logic key, input logic hv);
    @(posedge clk);
    lowVoltKeySeen <= key;
    highVoltOnResetPin <= hv;
  endtask
endmodule

// ---- config_word_guard_tb.sv ----
// Self-checking bench for the configuration word guard
`timescale 1ns/1ps
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module config_word_guard_tb;
  import cfg_guard_pkg::*;
  // Arbitrary identification values for this bench
  localparam logic [8:0] partCode = 9'h12d;
  localparam logic [4:0] revCode = 5'h03;
  typedef struct packed {logic [13:0] one; logic [13:0] two;} row_t;
  // Ordinary cases: word one and word two, one per protect field code
  row_t rows [4] = '{'{14'h3fff, 14'h3fff}, '{14'h3f7f, 14'h0002},
                     '{14'h3fff, 14'h2a11}, '{14'h3f7f, 14'h1400}};
  logic clk, rst, nvmBlank, lowVoltKeySeen, highVoltOnResetPin, stackOverflow, stackUnderflow;
  logic cpuRdReq, cpuWrReq, extRdReq, extWrReq, regWr, regRd;
  logic [13:0] nvmCfgOne, nvmCfgTwo, cpuWrAddr, memRdData, regWrData, extRdData, regRdData;
  logic [15:0] regAddr;
  cfg_controls_t controls;
  logic progModeEntry, stackFaultReset, cpuRdGrant, cpuWrGrant, cpuWrBlocked;
  logic extRdGrant, extWrGrant, configValid;
  // Outputs of the large, regulator-less instance
  cfg_controls_t controlsL;
  logic cpuWrGrantL, cpuWrBlockedL;
  int mismatches = 0; // Failed comparisons
  int numChecks = 0; // Comparisons made
  // Device under test, small array with regulator
  config_word_guard #(.PART_CODE(partCode), .SILICON_REV(revCode)) u_config_word_guard (
    .clk, .rst, .nvmCfgOne, .nvmCfgTwo, .nvmBlank, .lowVoltKeySeen, .highVoltOnResetPin,
    .stackOverflow, .stackUnderflow, .cpuRdReq, .cpuWrReq, .cpuWrAddr, .extRdReq, .extWrReq,
    .memRdData, .regAddr, .regWrData, .regWr, .regRd, .controls, .progModeEntry,
    .stackFaultReset, .cpuRdGrant, .cpuWrGrant, .cpuWrBlocked, .extRdGrant, .extWrGrant,
    .extRdData, .regRdData, .configValid);
  // Far-side programmer
  prog_model prog (.clk, .extRdReq, .extWrReq, .memRdData, .lowVoltKeySeen,
    .highVoltOnResetPin);
  // Second device: large array, no regulator, same inputs
  config_word_guard #(.LARGE_ARRAY(1'b1), .REGULATOR_PRESENT(1'b0), .PART_CODE(partCode),
    .SILICON_REV(revCode)) u_config_word_guard_large (
    .clk, .rst, .nvmCfgOne, .nvmCfgTwo, .nvmBlank, .lowVoltKeySeen, .highVoltOnResetPin,
    .stackOverflow, .stackUnderflow, .cpuRdReq, .cpuWrReq, .cpuWrAddr, .extRdReq, .extWrReq,
    .memRdData, .regAddr, .regWrData, .regWr, .regRd, .controls(controlsL),
    .progModeEntry(), .stackFaultReset(), .cpuRdGrant(), .cpuWrGrant(cpuWrGrantL),
    .cpuWrBlocked(cpuWrBlockedL), .extRdGrant(), .extWrGrant(), .extRdData(), .regRdData(),
    .configValid());
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Expected decoded controls from the two words
  function automatic cfg_controls_t expCtl(logic [13:0] one, logic [13:0] two);
    return '{two[13], !two[12], two[12], !two[11], two[10], two[9], !two[4], !one[7]};
  endfunction
  // Last self-write protected address of the small array
  function automatic logic [13:0] wpEnd(logic [1:0] f);
    return (f == 2'h2) ? 14'h01ff : (f == 2'h1) ? 14'h0fff : 14'h1fff;
  endfunction
  // Last self-write protected address of the large array
  function automatic logic [13:0] wpEndL(logic [1:0] f);
    return (f == 2'h2) ? 14'h01ff : (f == 2'h1) ? 14'h1fff : 14'h3fff;
  endfunction
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Reset for two cycles with given words, then wait bounded for the load
  task automatic boot(logic [13:0] one, logic [13:0] two, logic blank);
    int i;
    @(posedge clk);
    nvmCfgOne <= one;
    nvmCfgTwo <= two;
    nvmBlank <= blank;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 8 && configValid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (configValid !== 1'b1) begin
      mismatches++;
      test_done();
    end
  endtask
  // CPU request pulse; answer sampled in the following cycle
  task automatic cpu(logic rd, logic wr, logic [13:0] a);
    @(posedge clk);
    cpuRdReq <= rd;
    cpuWrReq <= wr;
    cpuWrAddr <= a;
    @(posedge clk);
    cpuRdReq <= 1'b0;
    cpuWrReq <= 1'b0;
    #1;
  endtask
  // Register bus cycle; read data sampled in the following cycle
  task automatic rreg(logic wr, logic [15:0] a, logic [13:0] d);
    @(posedge clk);
    regWr <= wr;
    regRd <= !wr;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    #1;
  endtask
  // Main sequence
  initial begin
    int k;
    row_t r;
    logic [13:0] e;
    rst = 1'b1;
    {nvmBlank, stackOverflow, stackUnderflow, cpuRdReq, cpuWrReq, regWr, regRd} = '0;
    {nvmCfgOne, nvmCfgTwo, cpuWrAddr, regWrData} = '0;
    regAddr = 16'h0000;
    // Table of ordinary cases
    for (k = 0; k < 4; k++) begin
      r = rows[k];
      e = wpEnd(r.two[1:0]);
      boot(r.one, r.two, 1'b0);
      `CHK("controls", expCtl(r.one, r.two), controls)
      `CHK("large cap", 1'b0, controlsL.regulatorCapFunction)
      rreg(1'b0, 16'h8008, 14'h0000);
      `CHK("word two", r.two | 14'h01ec, regRdData)
      cpu(1'b1, 1'b1, e);
      `CHK("cpu read", 1'b1, cpuRdGrant)
      `CHK("blocked at end", r.two[1:0] != 2'h3, cpuWrBlocked)
      `CHK("grant at end", r.two[1:0] == 2'h3, cpuWrGrant)
      `CHK("large blocked at end", r.two[1:0] != 2'h3, cpuWrBlockedL)
      if (r.two[1:0] != 2'h0) begin
        cpu(1'b0, 1'b1, e + 14'h0001);
        `CHK("grant above", 1'b1, cpuWrGrant)
        `CHK("large above", r.two[1:0] == 2'h1, cpuWrBlockedL)
        cpu(1'b0, 1'b1, wpEndL(r.two[1:0]) + 14'h0001);
        `CHK("large grant above", 1'b1, cpuWrGrantL)
      end else begin
        cpu(1'b0, 1'b1, 14'h3fff);
        `CHK("large top", 1'b1, cpuWrBlockedL)
      end
      prog.access(1'b1, 14'h2a5a);
      #1;
      `CHK("ext data", r.one[7] ? 14'h2a5a : 14'h0000, extRdData)
      `CHK("ext read", r.one[7], extRdGrant)
      prog.access(1'b0, 14'h0000);
      #1;
      `CHK("ext write", r.one[7], extWrGrant)
      @(posedge clk);
      stackOverflow <= !k[0];
      stackUnderflow <= k[0];
      @(posedge clk);
      stackOverflow <= 1'b0;
      stackUnderflow <= 1'b0;
      #1;
      `CHK("stack reset", r.two[9], stackFaultReset)
      prog.levels(1'b1, 1'b0);
      repeat (2) @(posedge clk);
      #1;
      `CHK("low volt entry", r.two[13], progModeEntry)
      prog.levels(1'b0, 1'b1);
      repeat (2) @(posedge clk);
      #1;
      `CHK("high volt entry", 1'b1, progModeEntry)
      prog.levels(1'b0, 1'b0);
    end
    // Word change after load leaves controls unchanged
    @(posedge clk);
    nvmCfgTwo <= 14'h3fff;
    repeat (3) @(posedge clk);
    #1;
    `CHK("held controls", expCtl(rows[3].one, rows[3].two), controls)
    // Mid-run reset: quiet in the capture cycle, new words valid one cycle later
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("release controls", 8'h00, controls)
    `CHK("release valid", 1'b0, configValid)
    @(posedge clk);
    #1;
    `CHK("reload valid", 1'b1, configValid)
    `CHK("reload controls", expCtl(rows[3].one, 14'h3fff), controls)
    // Blank array gives all ones
    boot(14'h0000, 14'h0000, 1'b1);
    `CHK("blank controls", expCtl(14'h3fff, 14'h3fff), controls)
    rreg(1'b0, 16'h8008, 14'h0000);
    `CHK("blank word two", 14'h3fff, regRdData)
    rreg(1'b0, 16'h8007, 14'h0000);
    `CHK("blank word one", 14'h3fff, regRdData)
    // User words, read-only identification, unmapped place
    rreg(1'b1, 16'h8000, 14'h1234);
    rreg(1'b1, 16'h8003, 14'h0abc);
    rreg(1'b1, 16'h8006, 14'h0000);
    rreg(1'b0, 16'h8000, 14'h0000);
    `CHK("user id 0", 14'h1234, regRdData)
    rreg(1'b0, 16'h8003, 14'h0000);
    `CHK("user id 3", 14'h0abc, regRdData)
    rreg(1'b0, 16'h8006, 14'h0000);
    `CHK("ident", {partCode, revCode}, regRdData)
    rreg(1'b0, 16'h9000, 14'h0000);
    `CHK("unmapped", 14'h0000, regRdData)
    // Write then read one user word with no gap; read data stand one cycle only
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= 16'h8001;
    regWrData <= 14'h0555;
    @(posedge clk);
    regWr <= 1'b0;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    `CHK("user id 1", 14'h0555, regRdData)
    @(posedge clk);
    #1;
    `CHK("read data gone", 14'h0000, regRdData)
    test_done();
  end
endmodule
